// *** bench/mtimer_monitor.sv ***
// Purpose: Port checks of the timer channel.
// Assumes: Bound to multimode_timer.
// Notes: Tracks the mode field from control writes.
`timescale 1ns/100ps
`default_nettype none
module mtimer_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Pins
    input wire logic pulseOutputPin,
    input wire logic timerIrqReq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------
    // Helper state and properties
    // ------------------------------
    logic acc;
    logic ctlWr;
    logic [1:0] mode_q;
    assign acc = psel && penable;
    assign ctlWr = acc && pwrite && paddr == 8'h00;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= 2'h0;
        end else if (ctlWr) begin
            mode_q <= pwdata[3:2];
        end
    end
    a_slverr_map: assert property (acc |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
        else $error("pslverr wrong");
    a_upper_zero: assert property (acc && !pwrite && paddr != 8'h00 |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !pulseOutputPin && !timerIrqReq)
        else $error("outputs not quiet after reset");
    a_rdata_hold: assert property ($changed(prdata) && !$past(sys_rst) |-> $past(psel && !penable && !pwrite))
        else $error("read data changed outside a read setup");
    a_irq_sticky: assert property (timerIrqReq && !(acc && pwrite && paddr == 8'h08 && !pwdata[0]) |=> timerIrqReq)
        else $error("request bit dropped");
    a_mode_irq: assert property (ctlWr && !mode_q[1] && pwdata[3] |=> timerIrqReq)
        else $error("no request on mode entry");
    a_fall_irq: assert property ($fell(pulseOutputPin) && !$past(ctlWr) && !$past(sys_rst) |-> ##[0:3] timerIrqReq)
        else $error("output fell without request");
    a_stop_low: assert property (ctlWr && !pwdata[0] |=> !pulseOutputPin)
        else $error("output high after stop");
endmodule
`default_nettype wire

// *** bench/tb_multimode_timer.sv ***
// Purpose: Self-checking bench for the timer channel.
// Assumes: Zero-wait APB slave, div1 source unless looped.
// Notes: Expected values come from integer arithmetic here.
`timescale 1ns/100ps
`default_nettype none
module tb_multimode_timer;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, trig, subClk, ovB1, ovX0, ovX2, pulse, irq;
    int n_mismatch = 0, n_checks = 0, n, m, c;
    int divs[4] = '{1, 8, 32, 192};
    initial begin
        forever #12.5 clk = !clk;
    end
    multimode_timer dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .triggerInputPin(trig), .subClockIn(subClk), .peerTimerB1Ovf(ovB1), .peerTimerX0Ovf(ovX0),
        .peerTimerX2Ovf(ovX2), .pulseOutputPin(pulse), .timerIrqReq(irq));
    trigger_source partner (.clk(clk), .triggerInputPin(trig), .subClockIn(subClk), .peerTimerB1Ovf(ovB1),
        .peerTimerX0Ovf(ovX0), .peerTimerX2Ovf(ovX2));
    // ------------------------------
    // Bus and compare tasks
    // ------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic hightime(output int cnt);
        cnt = 0;
        for (int i = 0; i < 20 && pulse !== 1'b1; i++) @(posedge clk);
        while (pulse === 1'b1 && cnt < 70000) begin
            @(posedge clk);
            cnt++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        void'($urandom(12));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk("ctrl", 8'h00, 32'h0);
        rdchk("timer", 8'h04, 32'h0);
        rdchk("status", 8'h08, 32'h0);
        rdchk("unmapped", 8'h0C, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("test reset done");
        n = $urandom_range(60, 16);
        apb(1'b1, 8'h04, n);
        rdchk("readback", 8'h04, n);
        apb(1'b1, 8'h00, 32'h04C);
        rdchk("pwm entry irq", 8'h08, 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        rdchk("irq clear", 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h04D);
        partner.pinEdge(1'b1);
        hightime(c);
        chk("pwm16 high", n, c);
        rdchk("pwm16 irq", 8'h08, 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h04C);
        rdchk("stop low irq", 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h04D);
        partner.pinEdge(1'b1);
        repeat (6) @(posedge clk);
        chk("restart high", 32'h1, {31'h0, pulse});
        apb(1'b1, 8'h00, 32'h04C);
        repeat (2) @(posedge clk);
        chk("stop pin", 32'h0, {31'h0, pulse});
        rdchk("stop high irq", 8'h08, 32'h1);
        $display("test pwm16 done");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h03C);
        rdchk("pwm8 entry irq", 8'h08, 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        m = $urandom_range(3, 1);
        n = $urandom_range(8, 2);
        apb(1'b1, 8'h04, n * 256 + m);
        apb(1'b1, 8'h00, 32'h03D);
        partner.pinEdge(1'b0);
        hightime(c);
        chk("pwm8 high", n * (m + 1), c);
        rdchk("pwm8 irq", 8'h08, 32'h1);
        $display("test pwm8 done");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h04, 32'h14);
        apb(1'b1, 8'h00, 32'h008);
        rdchk("oneshot entry irq", 8'h08, 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h009);
        apb(1'b1, 8'h00, 32'h00B);
        repeat (3) @(posedge clk);
        chk("oneshot high", 32'h1, {31'h0, pulse});
        apb(1'b1, 8'h00, 32'h008);
        rdchk("oneshot stop irq", 8'h08, 32'h1);
        rdchk("oneshot reload", 8'h04, 32'h14);
        $display("test oneshot done");
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        rdchk("reload read", 8'h04, 32'hFFFF);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 8'h00, s * 256);
            apb(1'b1, 8'h04, 32'h3);
            apb(1'b1, 8'h08, 32'h0);
            apb(1'b1, 8'h00, s * 256 + 1);
            for (c = 0; c < 2000 && irq !== 1'b1; c++) @(posedge clk);
            chk("source period", 32'h1, {31'h0, c >= 2 * divs[s] && c <= 4 * divs[s] + 8});
        end
        $display("test sources done");
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 8'h00, 32'h004);
            apb(1'b1, 8'h04, 32'hA);
            apb(1'b1, 8'h00, (k + 3) * 32 + 5);
            partner.peer(k);
            partner.peer(k);
            repeat (3) @(posedge clk);
            rdchk("peer count", 8'h04, 32'h8);
        end
        $display("test peers done");
        give_verdict();
    end
endmodule
bind multimode_timer mtimer_monitor mon (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .pulseOutputPin(pulseOutputPin), .timerIrqReq(timerIrqReq));
`default_nettype wire

// *** bench/trigger_source.sv ***
// Purpose: Far side: trigger pin, secondary clock, peer overflows.
// Assumes: Driven by the bench through its tasks.
// Notes: The secondary clock runs free at one sixth of clk.
`timescale 1ns/100ps
`default_nettype none
module trigger_source (
    // Clock
    input wire logic clk,
    // Toward the timer
    output logic triggerInputPin,
    output logic subClockIn,
    output logic peerTimerB1Ovf,
    output logic peerTimerX0Ovf,
    output logic peerTimerX2Ovf
);
    int phase_q;
    initial begin
        triggerInputPin = 1'b0;
        subClockIn = 1'b0;
        {peerTimerX2Ovf, peerTimerX0Ovf, peerTimerB1Ovf} = 3'h0;
        phase_q = 0;
    end
    always @(posedge clk) begin
        phase_q <= (phase_q + 1) % 3;
        if (phase_q == 2) begin
            subClockIn <= !subClockIn;
        end
    end
    task automatic pinEdge(input logic lvl);
        @(posedge clk);
        triggerInputPin <= !lvl;
        repeat (4) @(posedge clk);
        triggerInputPin <= lvl;
    endtask
    task automatic peer(input int k);
        @(posedge clk);
        {peerTimerX2Ovf, peerTimerX0Ovf, peerTimerB1Ovf} <= 3'h1 << k;
        @(posedge clk);
        {peerTimerX2Ovf, peerTimerX0Ovf, peerTimerB1Ovf} <= 3'h0;
    endtask
endmodule
`default_nettype wire

// *** hw/mtimer_consts.svh ***
// Purpose: Register map, field positions, reset values and counts of the timer channel.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Definitions only.
//
// Overview of operation
// [RL1] Count source is div1, div8, div32 or the divided subclock, software selected.
// [RL2] Start condition: pin falling/rising edge or peer timer overflow.
// [RL3] 16-bit PWM rising trigger with start flag set starts count, output high.
// [RL4] 8-bit PWM falling trigger with start flag set starts count, output high.
// [RL5] After the high time the output falls and the request bit sets.
// [RL6] PWM reloads at every cycle end and keeps counting.
// [RL7] Clearing start flag in PWM freezes the counter and drives output low.
// [RL8] 16-bit PWM period is 65535 source cycles, high time n cycles.
// [RL9] 16-bit value zero stays low, all ones stays high, both request every cycle.
// [RL10] 8-bit PWM period (m+1)*255 cycles, high time n*(m+1) cycles.
// [RL11] 8-bit upper byte zero stays low, all ones high, both request every cycle.
// [RL12] Software keeps start flag low, writes the timer, then sets the flag.
// [RL13] Timer reads return the live count; read at a reload gives all ones.
// [RL14] Event counter read at reload: all ones on underflow, zeros on overflow.
// [RL15] Timer written while halted reads back the written value before counting.
// [RL16] With free-run type software rewrites the timer after stopping.
// [RL17] One-shot start flag cleared mid-count: stop, reload, output low, request set.
// [RL18] One-shot output is aligned to the count source, lagging at most one cycle.
// [RL19] Entering one-shot mode after reset or from timer/event sets the request bit.
// [RL20] Software clears the request bit after such a mode change.
// [RL21] One-shot retrigger: one more down count, then reload and continue.
// [RL22] Retriggers are spaced more than one count-source cycle apart.
// [RL23] Divided clocks are main clock by 1, 8, 32; subclock by 32.
// [RL24] Entering PWM mode after reset or from timer/event sets the request bit.
// [RL25] Stop in PWM while high: output low and request; while low: no change.
// [RL26] Request bit is sticky until software writes 0; hardware set wins.
`ifndef MTIMER_CONSTS_SVH
`define MTIMER_CONSTS_SVH

`define MT_ADDR_CTRL 8'h00
`define MT_ADDR_TIMER 8'h04
`define MT_ADDR_STATUS 8'h08

`define MT_CTRL_START 0
`define MT_CTRL_OSTART 1
`define MT_CTRL_MODE_LO 2
`define MT_CTRL_MODE_HI 3
`define MT_CTRL_PWM8 4
`define MT_CTRL_TRIG_LO 5
`define MT_CTRL_TRIG_HI 7
`define MT_CTRL_SRC_LO 8
`define MT_CTRL_SRC_HI 9
`define MT_CTRL_FREERUN 10
`define MT_CTRL_UP 11
`define MT_STAT_IRQ 0

`define MT_CTRL_RESET 12'h000
`define MT_TIMER_RESET 16'h0000

`define MT_DIV_MAIN8 8
`define MT_DIV_MAIN32 32
`define MT_DIV_SUB32 32

`define MT_PWM16_LAST 16'hFFFE
`define MT_PWM8_LAST 8'hFE

`endif

// *** hw/mtimer_pkg.sv ***
// Purpose: Types shared by the timer channel.
// Assumes: Nothing.
// Notes: Mode and selector codes match the control register fields.
package mtimer_pkg;
    typedef enum logic [1:0] {
        MODE_TIMER = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_ONESHOT = 2'h2,
        MODE_PWM = 2'h3
    } mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN = 3'b100
    } run_t;
    typedef enum logic [2:0] {
        TRG_SOFT = 3'h0,
        TRG_FALL = 3'h1,
        TRG_RISE = 3'h2,
        TRG_PEER_B1 = 3'h3,
        TRG_PEER_X0 = 3'h4,
        TRG_PEER_X2 = 3'h5
    } trig_sel_t;
endpackage

// *** hw/multimode_timer.sv ***
// Purpose: 16-bit timer channel: timer, event counter, one-shot and PWM modes.
// Assumes: APB slave with zero wait states; pins synchronous to clk.
// Notes: The request bit is a status bit that also drives the timerIrqReq output directly.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "mtimer_consts.svh"
module multimode_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and neighbour timers
    input wire logic triggerInputPin,
    input wire logic subClockIn,
    input wire logic peerTimerB1Ovf,
    input wire logic peerTimerX0Ovf,
    input wire logic peerTimerX2Ovf,
    output logic pulseOutputPin,
    output logic timerIrqReq
);
    import mtimer_pkg::*;

    // ----------------------------------------
    // Registers and decode
    // ----------------------------------------
    logic start_q;
    logic pwm8_q;
    logic freeRun_q;
    logic upCount_q;
    mode_t mode_q;
    trig_sel_t trigSel_q;
    logic [1:0] srcSel_q;
    logic [15:0] reload_q;
    logic [15:0] cnt_q;
    run_t st_q;
    logic out_q;
    logic [1:0] rtg_q;
    logic irq_q;
    logic irqEvt_q;
    logic pinPrev_q;
    logic subPrev_q;
    logic [31:0] prdata_q;
    logic wrAcc;
    logic ctrlWr;
    logic timerWr;
    logic statWr;
    logic mapped;
    mode_t modeWr;
    logic startFall;
    logic osStartWr;
    logic modeEnterIrq;
    assign wrAcc = psel && penable && pwrite;
    assign mapped = (paddr == `MT_ADDR_CTRL) || (paddr == `MT_ADDR_TIMER) || (paddr == `MT_ADDR_STATUS);
    assign ctrlWr = wrAcc && (paddr == `MT_ADDR_CTRL);
    assign timerWr = wrAcc && (paddr == `MT_ADDR_TIMER);
    assign statWr = wrAcc && (paddr == `MT_ADDR_STATUS);
    assign modeWr = mode_t'(pwdata[`MT_CTRL_MODE_HI:`MT_CTRL_MODE_LO]);
    assign startFall = ctrlWr && start_q && !pwdata[`MT_CTRL_START];
    assign osStartWr = ctrlWr && pwdata[`MT_CTRL_OSTART];
    // [RL19] [RL24] mode entry request
    assign modeEnterIrq = ctrlWr && (modeWr == MODE_ONESHOT || modeWr == MODE_PWM) &&
                          (mode_q == MODE_TIMER || mode_q == MODE_EVENT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;
    assign pulseOutputPin = out_q;
    assign timerIrqReq = irq_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start_q <= 1'b0;
            pwm8_q <= 1'b0;
            freeRun_q <= 1'b0;
            upCount_q <= 1'b0;
            mode_q <= MODE_TIMER;
            trigSel_q <= TRG_SOFT;
            srcSel_q <= 2'h0;
        end else if (ctrlWr) begin
            start_q <= pwdata[`MT_CTRL_START];
            pwm8_q <= pwdata[`MT_CTRL_PWM8];
            freeRun_q <= pwdata[`MT_CTRL_FREERUN];
            upCount_q <= pwdata[`MT_CTRL_UP];
            mode_q <= modeWr;
            trigSel_q <= trig_sel_t'(pwdata[`MT_CTRL_TRIG_HI:`MT_CTRL_TRIG_LO]);
            srcSel_q <= pwdata[`MT_CTRL_SRC_HI:`MT_CTRL_SRC_LO];
        end
    end
    // Writes while counting reach only the reload register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reload_q <= `MT_TIMER_RESET;
        end else if (timerWr) begin
            reload_q <= pwdata[15:0];
        end
    end
    // ----------------------------------------
    // Count sources and triggers
    // ----------------------------------------
    logic tick8;
    logic tick32;
    logic tickSub;
    logic srcTick;
    logic subEdge;
    logic trigEvt;
    logic osTrig;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinPrev_q <= 1'b0;
            subPrev_q <= 1'b0;
        end else begin
            pinPrev_q <= triggerInputPin;
            subPrev_q <= subClockIn;
        end
    end
    assign subEdge = subClockIn && !subPrev_q;
    // [RL23] clock dividers
    tick_divider #(.DIV(`MT_DIV_MAIN8)) u_div8 (
        .clk(clk),
        .sys_rst(sys_rst),
        .en(1'b1),
        .tick(tick8)
    );
    tick_divider #(.DIV(`MT_DIV_MAIN32)) u_div32 (
        .clk(clk),
        .sys_rst(sys_rst),
        .en(1'b1),
        .tick(tick32)
    );
    tick_divider #(.DIV(`MT_DIV_SUB32)) u_divsub (
        .clk(clk),
        .sys_rst(sys_rst),
        .en(subEdge),
        .tick(tickSub)
    );
    // [RL1] count source select
    always_comb begin
        case (srcSel_q)
            2'h0: srcTick = 1'b1;
            2'h1: srcTick = tick8;
            2'h2: srcTick = tick32;
            default: srcTick = tickSub;
        endcase
    end
    // [RL2] start condition select
    always_comb begin
        case (trigSel_q)
            TRG_FALL: trigEvt = pinPrev_q && !triggerInputPin;
            TRG_RISE: trigEvt = !pinPrev_q && triggerInputPin;
            TRG_PEER_B1: trigEvt = peerTimerB1Ovf;
            TRG_PEER_X0: trigEvt = peerTimerX0Ovf;
            TRG_PEER_X2: trigEvt = peerTimerX2Ovf;
            default: trigEvt = 1'b0;
        endcase
    end
    assign osTrig = (trigSel_q == TRG_SOFT) ? osStartWr : trigEvt;
    // ----------------------------------------
    // Timer and event counter reload
    // ----------------------------------------
    logic tmrReload;
    logic evtUnder;
    logic evtOver;
    logic reloadNow;
    assign tmrReload = (mode_q == MODE_TIMER) && start_q && srcTick && (cnt_q == 16'h0000) && !freeRun_q;
    assign evtUnder = (mode_q == MODE_EVENT) && start_q && trigEvt && !upCount_q && (cnt_q == 16'h0000);
    assign evtOver = (mode_q == MODE_EVENT) && start_q && trigEvt && upCount_q && (cnt_q == 16'hFFFF);
    assign reloadNow = tmrReload || ((evtUnder || evtOver) && !freeRun_q);
    // ----------------------------------------
    // PWM arithmetic
    // ----------------------------------------
    logic [16:0] highLen;
    logic [16:0] perLen;
    logic [15:0] stepVal;
    logic [16:0] eNext;
    logic [15:0] pwmStart;
    logic pwmFull;
    logic pwmZero;
    logic stepTick;
    // [RL8] [RL10] period and high time
    assign highLen = pwm8_q ? {9'h000, reload_q[15:8]} : {1'b0, reload_q};
    assign perLen = pwm8_q ? {9'h000, `MT_PWM8_LAST} + 17'h00001 : {1'b0, `MT_PWM16_LAST} + 17'h00001;
    assign stepVal = pwm8_q ? {8'h00, cnt_q[15:8]} : cnt_q;
    assign eNext = perLen - {1'b0, stepVal};
    assign pwmStart = pwm8_q ? {`MT_PWM8_LAST, reload_q[7:0]} : `MT_PWM16_LAST;
    assign pwmFull = highLen >= perLen;
    assign pwmZero = highLen == 17'h00000;
    assign stepTick = srcTick && (!pwm8_q || cnt_q[7:0] == 8'h00);
    // ----------------------------------------
    // Counting engine
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= `MT_TIMER_RESET;
            st_q <= ST_IDLE;
            out_q <= 1'b0;
            rtg_q <= 2'h0;
            irqEvt_q <= 1'b0;
        end else begin
            irqEvt_q <= 1'b0;
            if (timerWr && !start_q) begin
                // [RL15] halted write loads counter
                cnt_q <= pwdata[15:0];
                st_q <= ST_IDLE;
                out_q <= 1'b0;
                rtg_q <= 2'h0;
            end else if (ctrlWr && modeWr != mode_q) begin
                st_q <= ST_IDLE;
                out_q <= 1'b0;
                rtg_q <= 2'h0;
            end else if (startFall) begin
                st_q <= ST_IDLE;
                out_q <= 1'b0;
                rtg_q <= 2'h0;
                if (mode_q == MODE_ONESHOT) begin
                    // [RL17] stop and reload
                    cnt_q <= reload_q;
                    irqEvt_q <= (st_q != ST_IDLE);
                end else if (mode_q == MODE_PWM) begin
                    // [RL7] [RL25] freeze, request only if high
                    irqEvt_q <= out_q;
                end
            end else begin
                case (mode_q)
                    MODE_TIMER: begin
                        if (start_q && srcTick) begin
                            cnt_q <= tmrReload ? reload_q : cnt_q - 16'h0001;
                            irqEvt_q <= (cnt_q == 16'h0000);
                        end
                    end
                    MODE_EVENT: begin
                        if (start_q && trigEvt) begin
                            if (reloadNow) begin
                                cnt_q <= reload_q;
                            end else if (upCount_q) begin
                                cnt_q <= cnt_q + 16'h0001;
                            end else begin
                                cnt_q <= cnt_q - 16'h0001;
                            end
                            irqEvt_q <= evtUnder || evtOver;
                        end
                    end
                    MODE_ONESHOT: begin
                        case (st_q)
                            ST_IDLE: begin
                                if (start_q && osTrig) begin
                                    st_q <= ST_ARMED;
                                end
                            end
                            ST_ARMED: begin
                                // [RL18] output starts on the count source
                                if (srcTick) begin
                                    st_q <= ST_RUN;
                                    out_q <= 1'b1;
                                end
                            end
                            ST_RUN: begin
                                if (osTrig && rtg_q == 2'h0) begin
                                    rtg_q <= 2'h1;
                                end
                                if (srcTick) begin
                                    if (rtg_q == 2'h2) begin
                                        // [RL21] retrigger reload
                                        cnt_q <= reload_q;
                                        rtg_q <= 2'h0;
                                    end else if (cnt_q == 16'h0000) begin
                                        cnt_q <= reload_q;
                                        out_q <= 1'b0;
                                        st_q <= ST_IDLE;
                                        rtg_q <= 2'h0;
                                        irqEvt_q <= 1'b1;
                                    end else begin
                                        // [RL21] one further down count
                                        cnt_q <= cnt_q - 16'h0001;
                                        if (rtg_q == 2'h1) begin
                                            rtg_q <= 2'h2;
                                        end
                                    end
                                end
                            end
                            default: st_q <= ST_IDLE;
                        endcase
                    end
                    default: begin
                        case (st_q)
                            ST_RUN: begin
                                if (stepTick && stepVal == 16'h0000) begin
                                    // [RL6] reload at cycle end
                                    cnt_q <= pwmStart;
                                    out_q <= !pwmZero;
                                    // [RL9] [RL11] constant levels still request
                                    irqEvt_q <= pwmZero || pwmFull;
                                end else if (stepTick) begin
                                    cnt_q <= pwm8_q ? {cnt_q[15:8] - 8'h01, reload_q[7:0]} : cnt_q - 16'h0001;
                                    // [RL5] high time elapsed
                                    if (eNext == highLen) begin
                                        out_q <= 1'b0;
                                        irqEvt_q <= 1'b1;
                                    end
                                end else if (srcTick) begin
                                    cnt_q <= {cnt_q[15:8], cnt_q[7:0] - 8'h01};
                                end
                            end
                            default: begin
                                // [RL3] [RL4] trigger starts PWM high
                                if (start_q && osTrig) begin
                                    st_q <= ST_RUN;
                                    cnt_q <= pwmStart;
                                    out_q <= !pwmZero;
                                    irqEvt_q <= pwmZero;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Interrupt request bit
    // ----------------------------------------
    // [RL26] sticky, set beats clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else if (irqEvt_q || modeEnterIrq) begin
            irq_q <= 1'b1;
        end else if (statWr && !pwdata[`MT_STAT_IRQ]) begin
            irq_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `MT_ADDR_CTRL: begin
                    prdata_q <= {20'h00000, upCount_q, freeRun_q, srcSel_q, trigSel_q, pwm8_q, mode_q,
                                 1'b0, start_q};
                end
                `MT_ADDR_TIMER: begin
                    // [RL13] [RL14] live count, fixed value at reload
                    if (reloadNow) begin
                        prdata_q <= evtOver ? 32'h00000000 : 32'h0000FFFF;
                    end else begin
                        prdata_q <= {16'h0000, cnt_q};
                    end
                end
                `MT_ADDR_STATUS: prdata_q <= {31'h00000000, irq_q};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** hw/tick_divider.sv ***
// Purpose: Divides an enable stream into one-cycle tick pulses.
// Assumes: One clock; en marks the input events.
// Notes: A tick is issued on every DIV-th enable.
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
    parameter int DIV = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Event stream
    input wire logic en,
    output logic tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (en) begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
        end
    end

    assign tick = en && (cnt_q == LAST);
endmodule
`default_nettype wire
